// ### rtl/dmt_pkg.sv
// Timing constants, command codes and states of the DRAM mode/training sequencer
package dmt_pkg;

  // Clock of the controller itself
  localparam int SYS_PERIOD_PS = 50000;

  // Device timing figures, as times in ps and as cycle counts
  localparam int BOOT_CLOCK_PERIOD_PS = 18000;
  localparam int MR_WRITE_SPACING_PS = 10000;
  localparam int MR_WRITE_SPACING_NCK = 10;
  localparam int MR_READ_SPACING_NCK = 8;
  localparam int MR_WRITE_SETTLE_PS = 14000;
  localparam int MR_WRITE_SETTLE_NCK = 10;
  localparam int POWER_DOWN_EXIT_PS = 7500;
  localparam int POWER_DOWN_EXIT_NCK = 5;
  localparam int ROW_TO_COLUMN_DELAY_PS = 18000;
  localparam int PD_EXIT_TO_MR_READ_EXTRA_NCK = 3;
  localparam int CLOCK_VALID_AFTER_CKE_LOW_PS = 5000;
  localparam int CLOCK_VALID_AFTER_CKE_LOW_NCK = 5;
  localparam int STROBE_STABLE_BEFORE_CKE_LOW_PS = 10000;
  localparam int ASYNC_TRAINING_READ_PS = 20000;
  localparam int CLOCK_BEFORE_SELECT_HIGH_NCK = 2;
  localparam int CLOCK_AFTER_SELECT_HIGH_PS = 7500;
  localparam int CLOCK_AFTER_SELECT_HIGH_NCK = 5;
  localparam int SELECT_TO_STROBE_TOGGLE_NCK = 2;
  localparam int CLOCK_AFTER_STROBE_TOGGLE_PS = 7500;
  localparam int CLOCK_AFTER_STROBE_TOGGLE_NCK = 4;

  function automatic int div_up(input int num, input int den);
    return (num + den - 1) / den;
  endfunction

  function automatic int max_int(input int a, input int b);
    return (a > b) ? a : b;
  endfunction

  // Half period of the device clock in controller cycles, never faster than boot limit
  localparam int CK_HALF_SYS = max_int(1, div_up(BOOT_CLOCK_PERIOD_PS, 2 * SYS_PERIOD_PS));
  localparam int CK_PERIOD_PS = 2 * CK_HALF_SYS * SYS_PERIOD_PS;

  // Larger of a time and a cycle count, in device clock cycles, at least one
  function automatic int both_ck(input int ps, input int nck);
    return max_int(1, max_int(div_up(ps, CK_PERIOD_PS), nck));
  endfunction

  localparam logic [3:0] CK_HALF_END = 4'(CK_HALF_SYS - 1);
  localparam logic [7:0] MR_WRITE_SPACING_CK = 8'(both_ck(MR_WRITE_SPACING_PS,
                                                          MR_WRITE_SPACING_NCK));
  localparam logic [7:0] MR_READ_SPACING_CK = 8'(MR_READ_SPACING_NCK);
  localparam logic [7:0] MR_WRITE_SETTLE_CK = 8'(both_ck(MR_WRITE_SETTLE_PS,
                                                         MR_WRITE_SETTLE_NCK));
  localparam int POWER_DOWN_EXIT_CK_I = both_ck(POWER_DOWN_EXIT_PS, POWER_DOWN_EXIT_NCK);
  localparam logic [7:0] PD_EXIT_TO_MR_READ_CK = 8'(POWER_DOWN_EXIT_CK_I
      + div_up(ROW_TO_COLUMN_DELAY_PS, CK_PERIOD_PS) + PD_EXIT_TO_MR_READ_EXTRA_NCK);
  localparam logic [7:0] CLOCK_VALID_AFTER_CKE_LOW_CK = 8'(both_ck(
      CLOCK_VALID_AFTER_CKE_LOW_PS, CLOCK_VALID_AFTER_CKE_LOW_NCK));
  localparam logic [7:0] STROBE_STABLE_CK = 8'(both_ck(STROBE_STABLE_BEFORE_CKE_LOW_PS, 1));
  localparam logic [7:0] TRAINING_CMD_SPACING_CK = 8'(both_ck(ASYNC_TRAINING_READ_PS, 1));
  localparam logic [7:0] CLOCK_BEFORE_SELECT_CK = 8'(CLOCK_BEFORE_SELECT_HIGH_NCK
      + POWER_DOWN_EXIT_CK_I);
  localparam logic [7:0] CLOCK_AFTER_SELECT_CK = 8'(both_ck(CLOCK_AFTER_SELECT_HIGH_PS,
                                                            CLOCK_AFTER_SELECT_HIGH_NCK));
  localparam logic [7:0] SELECT_TO_STROBE_CK = 8'(SELECT_TO_STROBE_TOGGLE_NCK);
  localparam logic [7:0] CLOCK_AFTER_STROBE_CK = 8'(both_ck(CLOCK_AFTER_STROBE_TOGGLE_PS,
                                                            CLOCK_AFTER_STROBE_TOGGLE_NCK));

  typedef enum logic [3:0] {
    OP_MRW       = 4'h0,
    OP_MRR       = 4'h1,
    OP_OTHER     = 4'h2,
    OP_PD_ENTER  = 4'h3,
    OP_PD_EXIT   = 4'h4,
    OP_CBT_ENTER = 4'h5,
    OP_CBT_CMD   = 4'h6,
    OP_CBT_VREF  = 4'h7,
    OP_CBT_EXIT  = 4'h8,
    OP_WL_STROBE = 4'h9
  } dmt_op_t;

  typedef enum logic [3:0] {
    ST_ACTIVE   = 4'b0001,
    ST_PDOWN    = 4'b0010,
    ST_CBT_PREP = 4'b0100,
    ST_CBT      = 4'b1000
  } dmt_state_t;

endpackage

// ### rtl/dmt_ctrl.sv
// Host-side command sequencer that spaces mode-register, training and leveling commands
//
// Behaviour
// RULE1: The device clock is divided down so its period is never shorter than 18 ns.
// RULE2: A mode register read waits the power-down exit delay, the row-to-column delay and 3 more cycles after power-down exit.
// RULE3: Two mode register writes are at least the larger of 10 ns and 10 cycles apart.
// RULE4: Two mode register reads are at least 8 cycles apart.
// RULE5: After a mode register write, other commands wait the larger of 14 ns and 10 cycles.
// RULE6: After clock enable drops for bus training the clock keeps running at least the larger of 5 ns and 5 cycles.
// RULE7: Only a training sample followed by the asynchronous read time is captured; earlier crowded samples are dropped.
// RULE8: The true strobe is held low and the complement high for the stable time before clock enable drops for training.
// RULE9: In training, chip select rises only after the clock has run two cycles plus the power-down exit delay.
// RULE10: In training, the clock keeps running after a chip select pulse for the larger of 7.5 ns and 5 cycles.
// RULE11: In training, a strobe toggle waits at least 2 cycles after chip select.
// RULE12: In write leveling, the clock keeps running after the last strobe toggle for the larger of 7.5 ns and 4 cycles.
// RULE13: Every delay made of a time and a cycle count expires only when both are met.
`timescale 1ns/1ps
module dmt_ctrl (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic cmd_valid,
  input wire dmt_pkg::dmt_op_t cmd_op,
  input wire logic [5:0] cmd_ca,
  input wire logic ck_stop_req,
  input wire logic [5:0] dq_i,
  output logic cmd_ack,
  output logic [5:0] cbt_result,
  output logic cbt_result_valid,
  output logic ck_t,
  output logic ck_c,
  output logic cke,
  output logic cs,
  output logic [5:0] ca,
  output logic dqs_t_o,
  output logic dqs_t_oe,
  output logic dqs_c_o,
  output logic dqs_c_oe
);
  import dmt_pkg::*;

  function automatic logic [7:0] dec8(input logic [7:0] v);
    return (v == 8'h00) ? 8'h00 : v - 8'h01;
  endfunction

  function automatic logic [7:0] max8(input logic [7:0] a, input logic [7:0] b);
    return (a > b) ? a : b;
  endfunction

  function automatic logic [7:0] inc8(input logic [7:0] v);
    return (v == 8'hff) ? 8'hff : v + 8'h01;
  endfunction

  dmt_state_t state_q;
  logic [3:0] div_q;
  logic ck_t_q, ck_c_q, ck_run_q, dqs_c_q;
  logic cke_q, cs_q, pulse_q, dqs_oe_q;
  logic [5:0] ca_q;
  logic [7:0] mrw_gap_q, mrr_gap_q, mrd_q, mrri_q, hold_q, prep_q;
  logic [7:0] since_clk_q, since_cs_q, adr_q;
  logic cs_seen_q, pend_q;
  logic [5:0] dq_s1_q, dq_s2_q;
  logic [5:0] result_q;
  logic result_valid_q, ack_q;
  logic div_end, tick, stop_ok, ok, accept;

  // One device cycle per falling edge; pins change there so they are stable at the rise
  assign div_end = (div_q == CK_HALF_END);
  assign tick = div_end && ck_t_q;
  assign stop_ok = ck_stop_req && (hold_q == 8'h00) && !cs_q && !pulse_q
                   && (state_q != ST_CBT_PREP);

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      div_q <= 4'h0;
      ck_t_q <= 1'b0;
      ck_c_q <= 1'b1;
      ck_run_q <= 1'b1;
    end else if (!ck_run_q) begin
      ck_run_q <= !ck_stop_req;
      div_q <= 4'h0;
    end else if (div_end) begin
      div_q <= 4'h0;
      if (ck_t_q) begin
        ck_t_q <= 1'b0;
        ck_c_q <= 1'b1;
      end else if (stop_ok) begin
        ck_run_q <= 1'b0; // Clock parks low, only once every clock-hold interval is spent
      end else begin
        ck_t_q <= 1'b1; // RULE1
        ck_c_q <= 1'b0;
      end
    end else begin
      div_q <= div_q + 4'h1;
    end
  end

  // Which commands the current state and the spacing timers allow
  always_comb begin
    ok = 1'b0;
    unique case (state_q)
      ST_ACTIVE: begin
        unique case (cmd_op)
          OP_MRW: ok = (mrw_gap_q == 8'h00); // RULE3
          OP_MRR: ok = (mrr_gap_q == 8'h00) && (mrri_q == 8'h00) && (mrd_q == 8'h00); // RULE2
          OP_OTHER, OP_PD_ENTER, OP_CBT_ENTER: ok = (mrd_q == 8'h00); // RULE5
          OP_WL_STROBE: ok = (mrd_q == 8'h00) && !pulse_q;
          default: ok = 1'b0;
        endcase
      end
      ST_PDOWN: ok = (cmd_op == OP_PD_EXIT);
      ST_CBT: begin
        unique case (cmd_op)
          OP_CBT_CMD: ok = (since_clk_q >= CLOCK_BEFORE_SELECT_CK); // RULE9
          OP_CBT_VREF: ok = cs_seen_q && (since_cs_q >= SELECT_TO_STROBE_CK) && !pulse_q; // RULE11
          OP_CBT_EXIT: ok = !pulse_q;
          default: ok = 1'b0;
        endcase
      end
      ST_CBT_PREP: ok = 1'b0;
    endcase
  end

  assign accept = cmd_valid && tick && ok;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_q <= ST_ACTIVE;
      prep_q <= 8'h00;
    end else if (tick) begin
      prep_q <= dec8(prep_q);
      if (state_q == ST_CBT_PREP && prep_q == 8'h00) begin
        state_q <= ST_CBT;
      end else if (accept) begin
        unique case (cmd_op)
          OP_PD_ENTER: state_q <= ST_PDOWN;
          OP_PD_EXIT, OP_CBT_EXIT: state_q <= ST_ACTIVE;
          OP_CBT_ENTER: begin
            state_q <= ST_CBT_PREP;
            prep_q <= STROBE_STABLE_CK; // RULE8
          end
          default: state_q <= state_q;
        endcase
      end
    end
  end

  // Pin drive: command, clock enable and strobes
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cke_q <= 1'b1;
      cs_q <= 1'b0;
      ca_q <= 6'h00;
      pulse_q <= 1'b0;
      dqs_c_q <= 1'b1;
      dqs_oe_q <= 1'b0;
    end else if (tick) begin
      cs_q <= 1'b0;
      pulse_q <= 1'b0;
      dqs_c_q <= 1'b1;
      dqs_oe_q <= (state_q == ST_CBT_PREP) || (state_q == ST_CBT);
      if (state_q == ST_CBT_PREP && prep_q == 8'h00) begin
        cke_q <= 1'b0; // RULE8
      end else if (accept) begin
        unique case (cmd_op)
          OP_MRW, OP_MRR, OP_OTHER, OP_CBT_CMD: begin
            cs_q <= 1'b1;
            ca_q <= cmd_ca;
          end
          OP_PD_ENTER: cke_q <= 1'b0;
          OP_PD_EXIT, OP_CBT_EXIT: cke_q <= 1'b1;
          OP_CBT_ENTER: dqs_oe_q <= 1'b1; // RULE8
          OP_CBT_VREF, OP_WL_STROBE: begin
            pulse_q <= 1'b1;
            dqs_c_q <= 1'b0;
            dqs_oe_q <= 1'b1;
          end
          default: cs_q <= 1'b0;
        endcase
      end
    end
  end

  // Spacing timers, all counted in device clock cycles
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      mrw_gap_q <= 8'h00;
      mrr_gap_q <= 8'h00;
      mrd_q <= 8'h00;
      mrri_q <= 8'h00;
      hold_q <= 8'h00;
      since_clk_q <= 8'h00;
      since_cs_q <= 8'h00;
      cs_seen_q <= 1'b0;
    end else if (!ck_run_q) begin
      since_clk_q <= 8'h00; // Stopped clock must build up its run time again
    end else if (tick) begin
      mrw_gap_q <= dec8(mrw_gap_q);
      mrr_gap_q <= dec8(mrr_gap_q);
      mrd_q <= dec8(mrd_q);
      mrri_q <= dec8(mrri_q);
      hold_q <= dec8(hold_q);
      since_clk_q <= inc8(since_clk_q);
      since_cs_q <= inc8(since_cs_q);
      if (state_q == ST_CBT_PREP && prep_q == 8'h00) begin
        hold_q <= max8(dec8(hold_q), CLOCK_VALID_AFTER_CKE_LOW_CK); // RULE6 RULE13
        cs_seen_q <= 1'b0;
      end else if (accept) begin
        unique case (cmd_op)
          OP_MRW: begin
            mrw_gap_q <= MR_WRITE_SPACING_CK; // RULE3 RULE13
            mrd_q <= MR_WRITE_SETTLE_CK; // RULE5 RULE13
          end
          OP_MRR: mrr_gap_q <= MR_READ_SPACING_CK; // RULE4
          OP_PD_ENTER: hold_q <= max8(dec8(hold_q), CLOCK_VALID_AFTER_CKE_LOW_CK);
          OP_PD_EXIT: mrri_q <= PD_EXIT_TO_MR_READ_CK; // RULE2
          OP_CBT_CMD: begin
            hold_q <= max8(dec8(hold_q), CLOCK_AFTER_SELECT_CK); // RULE10 RULE13
            since_cs_q <= 8'h00;
            cs_seen_q <= 1'b1;
          end
          OP_WL_STROBE: hold_q <= max8(dec8(hold_q), CLOCK_AFTER_STROBE_CK); // RULE12 RULE13
          default: hold_q <= dec8(hold_q);
        endcase
      end
    end
  end

  // Training echo: a sample counts only once the next command keeps its distance
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      dq_s1_q <= 6'h00;
      dq_s2_q <= 6'h00;
    end else begin
      dq_s1_q <= dq_i;
      dq_s2_q <= dq_s1_q;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      adr_q <= 8'h00;
      pend_q <= 1'b0;
      result_q <= 6'h00;
      result_valid_q <= 1'b0;
    end else begin
      result_valid_q <= 1'b0;
      if (tick) begin
        adr_q <= dec8(adr_q);
        if (pend_q && adr_q == 8'h00) begin
          result_q <= dq_s2_q; // RULE7
          result_valid_q <= 1'b1;
          pend_q <= 1'b0;
        end
        if (accept && cmd_op == OP_CBT_CMD) begin
          adr_q <= TRAINING_CMD_SPACING_CK; // RULE7
          pend_q <= 1'b1;
        end
        if (state_q != ST_CBT) begin
          pend_q <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= accept;
    end
  end

  assign cmd_ack = ack_q;
  assign cbt_result = result_q;
  assign cbt_result_valid = result_valid_q;
  assign ck_t = ck_t_q;
  assign ck_c = ck_c_q;
  assign cke = cke_q;
  assign cs = cs_q;
  assign ca = ca_q;
  assign dqs_t_o = pulse_q;
  assign dqs_t_oe = dqs_oe_q;
  assign dqs_c_o = dqs_c_q;
  assign dqs_c_oe = dqs_oe_q;

endmodule

// ### dv/dmt_checker.sv
// Concurrent timing checks on the ports of the mode and training sequencer
`timescale 1ns/1ps
module dmt_checker (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire dmt_pkg::dmt_op_t cmd_op,
  input wire logic cmd_ack,
  input wire logic ck_t,
  input wire logic cke,
  input wire logic cs,
  input wire logic dqs_t_o,
  input wire logic dqs_t_oe,
  input wire logic dqs_c_o
);
  import dmt_pkg::*;
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);
  // Counts in clk_sys cycles; one device cycle is two of them
  logic [7:0] mrw_q, mrr_q, pdx_q, ckel_q, park_q, run_q;
  logic ck_q, cke_q;
  // Op of the taken request; the port may already carry the next one while ack stands
  dmt_op_t op_q;
  function automatic logic [7:0] inc(input logic [7:0] v);
    return (v == 8'hff) ? v : v + 8'h01;
  endfunction
  always_ff @(posedge clk_sys) begin
    ck_q <= ck_t;
    op_q <= cmd_op;
    cke_q <= cke;
    park_q <= (dqs_t_oe && !dqs_t_o && dqs_c_o) ? inc(park_q) : 8'h00;
    run_q <= (ck_t != ck_q) ? inc(run_q) : 8'h00;
    // Saturated after reset so the first command is never flagged
    if (sys_rst) begin
      mrw_q <= 8'hff;
      mrr_q <= 8'hff;
      pdx_q <= 8'hff;
      ckel_q <= 8'hff;
    end else begin
      mrw_q <= (cmd_ack && op_q == OP_MRW) ? 8'h01 : inc(mrw_q);
      mrr_q <= (cmd_ack && op_q == OP_MRR) ? 8'h01 : inc(mrr_q);
      pdx_q <= (cmd_ack && op_q == OP_PD_EXIT) ? 8'h01 : inc(pdx_q);
      ckel_q <= (cke_q && !cke) ? 8'h01 : inc(ckel_q);
    end
  end
  sequence mrw_taken;
    cmd_ack && op_q == OP_MRW;
  endsequence
  sequence mrr_taken;
    cmd_ack && op_q == OP_MRR;
  endsequence
  ck_half_a: assert property ($rose(ck_t) |=> $fell(ck_t))
    else $error("device clock high phase wrong");
  mrw_gap_a: assert property (mrw_taken |-> mrw_q >= 8'd20)
    else $error("mode write spacing short");
  mrw_settle_a: assert property (cmd_ack && op_q != OP_MRW |-> mrw_q >= 8'd20)
    else $error("command too soon after mode write");
  mrr_gap_a: assert property (mrr_taken |-> mrr_q >= 8'd16)
    else $error("mode read spacing short");
  pdx_read_a: assert property (mrr_taken |-> pdx_q >= 8'd18)
    else $error("mode read too soon after power-down exit");
  cke_clock_a: assert property ($stable(ck_t) && !cke |-> ckel_q >= 8'd10)
    else $error("clock stopped too soon after cke low");
  // Power-down entry also drops cke but leaves the strobes undriven
  strobe_park_a: assert property ($fell(cke) && dqs_t_oe |-> park_q >= 8'd2)
    else $error("strobe not parked before cke low");
  select_clock_a: assert property ($rose(cs) && !cke |-> run_q >= 8'd12)
    else $error("select raised before clock ran long enough");
endmodule
bind dmt_ctrl dmt_checker i_chk (.clk_sys(clk_sys), .sys_rst(sys_rst), .cmd_op(cmd_op),
  .cmd_ack(cmd_ack), .ck_t(ck_t), .cke(cke), .cs(cs), .dqs_t_o(dqs_t_o),
  .dqs_t_oe(dqs_t_oe), .dqs_c_o(dqs_c_o));

// ### dv/dmt_dram_model.sv
// Behavioural device that echoes the training command word on its data lines
`timescale 1ns/1ps
module dmt_dram_model #(
  parameter int ADR_NS = 20
) (
  input wire logic ck_t,
  input wire logic cke,
  input wire logic cs,
  input wire logic [5:0] ca,
  output logic [5:0] dq
);
  logic [5:0] samp;
  initial dq = 6'h15;
  // Lines are not valid until the read time runs out, so show a wrong word
  always @(posedge ck_t) begin
    if (!cke && cs) begin
      samp = ca;
      dq = ~ca;
      #(ADR_NS) dq = samp;
    end else if (cke) begin
      dq = dq ^ 6'h2a;
    end
  end
endmodule

// ### dv/dmt_ctrl_tb_top.sv
// Self-checking bench for the mode and training sequencer
`timescale 1ns/1ps
module dmt_ctrl_tb_top;
  import dmt_pkg::*;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic cmd_valid = 1'b0;
  dmt_op_t cmd_op = OP_OTHER;
  logic [5:0] cmd_ca = 6'h00;
  logic ck_stop_req = 1'b0;
  logic [5:0] dq_i, cbt_result, ca;
  logic cmd_ack, cbt_result_valid, ck_t, ck_c, cke, cs;
  logic dqs_t_o, dqs_t_oe, dqs_c_o, dqs_c_oe, ck_prev;
  int fails = 0;
  int n_tests = 0;
  int cyc = 0;
  int ntog = 0;
  int t_ack = 0;
  int g_ack, t_rel, tog_ack;
  time tp;
  always #25 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    ck_prev <= ck_t;
    if (ck_t !== ck_prev) ntog <= ntog + 1;
  end
  dmt_ctrl i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .cmd_valid(cmd_valid),
    .cmd_op(cmd_op), .cmd_ca(cmd_ca), .ck_stop_req(ck_stop_req), .dq_i(dq_i),
    .cmd_ack(cmd_ack), .cbt_result(cbt_result), .cbt_result_valid(cbt_result_valid),
    .ck_t(ck_t), .ck_c(ck_c), .cke(cke), .cs(cs), .ca(ca), .dqs_t_o(dqs_t_o),
    .dqs_t_oe(dqs_t_oe), .dqs_c_o(dqs_c_o), .dqs_c_oe(dqs_c_oe));
  dmt_dram_model i_mem (.ck_t(ck_t), .cke(cke), .cs(cs), .ca(ca), .dq(dq_i));
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Holds the request past the edge that samples ack; returns before the next tick is reached
  task automatic issue(input dmt_op_t op, input logic [5:0] w);
    int n;
    n = 0;
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_ca = w;
    do begin
      @(negedge clk_sys);
      n++;
    end while (cmd_ack !== 1'b1 && n < 400);
    chk("cmd_ack", 8'h01, 8'(cmd_ack));
    g_ack = cyc - t_ack;
    t_ack = cyc;
    tog_ack = ntog;
    @(negedge clk_sys);
  endtask
  task automatic idle;
    cmd_valid = 1'b0;
    @(negedge clk_sys);
  endtask
  task automatic stop_clock(input int n0, input int min_t);
    ck_stop_req = 1'b1;
    repeat (30) @(negedge clk_sys);
    chk("ck toggles", 8'h01, 8'(ntog - n0 >= min_t && ntog - n0 < 28 && ck_t === 1'b0));
    ck_stop_req = 1'b0;
    t_rel = cyc;
    @(negedge clk_sys);
  endtask
  task automatic t_mode_reg;
    @(posedge ck_t);
    tp = $time;
    @(posedge ck_t);
    chk("ck period", 8'd100, 8'($time - tp));
    @(negedge clk_sys);
    chk("ck pair", 8'h01, 8'(ck_c === ~ck_t));
    issue(OP_MRW, 6'h11);
    chk("ca", 8'h11, {2'b00, ca});
    chk("cs", 8'h01, 8'(cs));
    issue(OP_MRW, 6'h22);
    // Ten cycles of spacing plus the tick that first sees the timer empty
    chk("mrw gap", 8'd22, 8'(g_ack));
    issue(OP_OTHER, 6'h05);
    chk("settle gap", 8'h01, 8'(g_ack >= 20));
    issue(OP_MRR, 6'h09);
    issue(OP_MRR, 6'h0a);
    chk("mrr gap", 8'h01, 8'(g_ack >= 16));
    issue(OP_PD_ENTER, 6'h00);
    idle();
    chk("cke in power-down", 8'h00, 8'(cke));
    issue(OP_PD_EXIT, 6'h00);
    issue(OP_MRR, 6'h0b);
    chk("exit to read gap", 8'h01, 8'(g_ack >= 18));
    idle();
  endtask
  task automatic t_train;
    int r;
    int k;
    issue(OP_CBT_ENTER, 6'h00);
    chk("strobe park", 8'h0d, {4'h0, dqs_c_oe, dqs_t_oe, dqs_t_o, dqs_c_o});
    idle();
    r = 0;
    while (cke !== 1'b0 && r < 20) begin
      @(negedge clk_sys);
      r++;
    end
    stop_clock(ntog, 10);
    issue(OP_CBT_CMD, 6'h2d);
    chk("restart gap", 8'h01, 8'(t_ack - t_rel >= 14));
    idle();
    stop_clock(tog_ack, 9);
    chk("cbt result", 8'h2d, {2'b00, cbt_result});
    issue(OP_CBT_CMD, 6'h0c);
    issue(OP_CBT_CMD, 6'h33);
    idle();
    k = 0;
    repeat (20) begin
      @(negedge clk_sys);
      if (cbt_result_valid === 1'b1) k++;
    end
    chk("captures", 8'h01, 8'(k));
    chk("cbt result", 8'h33, {2'b00, cbt_result});
    issue(OP_CBT_CMD, 6'h1e);
    issue(OP_CBT_VREF, 6'h00);
    chk("vref gap", 8'h01, 8'(g_ack >= 4));
    chk("vref strobe", 8'h01, 8'(dqs_t_o));
    idle();
    issue(OP_CBT_EXIT, 6'h00);
    idle();
    chk("cke after exit", 8'h01, 8'(cke));
  endtask
  task automatic t_level;
    issue(OP_WL_STROBE, 6'h00);
    chk("level strobe", 8'h01, 8'(dqs_t_o));
    idle();
    stop_clock(tog_ack, 8);
  endtask
  task automatic complete_run;
    $display("Checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (16) @(negedge clk_sys);
    sys_rst = 1'b0;
    t_mode_reg();
    t_train();
    t_level();
    complete_run();
  end
  // About twenty times the expected run length
  initial begin
    #300000;
    fails++;
    complete_run();
  end
endmodule
